/* logic/exec_pkg.sv */
package exec_pkg;
   // Quarter phases of one instruction cycle
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q3 = 2'h2;
   localparam logic [1:0] Q4 = 2'h3;
   // Opcode patterns
   localparam logic [6:0] CMP_LESS_OP = 7'h30;
   localparam logic [5:0] DEC_FILE_OP = 6'h01;
   localparam logic [15:0] DEC_ADJ_WORD = 16'h0007;
   localparam logic [3:0] MOVE_LONG_OP = 4'hC;
   localparam logic [5:0] BRANCH_LONG_OP = 6'h3B;
   // Addressing
   localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;
   // Decimal adjust
   localparam logic [3:0] NIBBLE_MAX = 4'h9;
   localparam logic [3:0] BCD_FIX = 4'h6;
   // Status bit positions
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;
   // Register port offsets
   localparam logic [2:0] OFS_ACC = 3'h0;
   localparam logic [2:0] OFS_STATUS = 3'h1;
   localparam logic [2:0] OFS_BANK = 3'h2;
   localparam logic [2:0] OFS_CTRL = 3'h3;
   localparam logic [2:0] OFS_IDX_LO = 3'h4;
   localparam logic [2:0] OFS_IDX_HI = 3'h5;
   // Reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [4:0] STATUS_RST = 5'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic EXT_RST = 1'b0;
   localparam logic [11:0] IDX_RST = 12'h000;

   typedef enum logic [1:0] {ST_EXEC = 2'b00, ST_SKIP_ONE = 2'b01, ST_SKIP_TWO = 2'b10} seq_t;
   typedef enum logic [1:0] {OP_NONE = 2'b00, OP_CMP = 2'b01, OP_DAA = 2'b10, OP_DEC = 2'b11} op_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } dm_req_t;
endpackage

/* logic/exec_unit.sv */
// How it works
// - Compare-skip-if-less takes 1 cycle, 2 to skip a one-word and 3 a two-word instruction.
// - Skipping a two-word instruction runs two whole cycles where every quarter does nothing.
// - Compare does unsigned file byte minus accumulator, skips if byte is less, flags kept.
// - Compare-skip-if-less decodes from top bits 0110000, then bank bit and 8-bit address.
// - Decimal adjust adds 6 to the low nibble when it is above 9 or the nibble carry is set.
// - Decimal adjust takes high nibble plus the low correction's carry, adds 6 if above 9 or carry set.
// - Decrement-file subtracts one, updating carry, nibble carry, negative, wrap and zero.
// - Decrement-file decodes from top bits 000001, then destination, bank bit, 8-bit address.
// - Destination 0 puts the decrement in the accumulator, 1 writes it back to file byte.
// - Bank bit 0 selects the access bank, 1 selects the user bank named by the bank pointer.
// - Bank bit 0 with extended set on and address at most 95 is an offset from index base.
module exec_unit
   import exec_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Program memory
   input wire logic [15:0] iword_i,
   output logic [1:0] q_phase_o,
   output logic cycle_end_o,
   output logic nop_cycle_o,
   // Data memory
   output dm_req_t dm_o,
   input wire logic [7:0] dm_rdata_i,
   // Register port
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o
);

   ////////////////////////////////////////////////////////////////////////
   logic [1:0] q, next_q;
   seq_t state, next_state;
   op_t op, next_op;
   logic dest_file, next_dest_file;
   logic skip, next_skip;
   logic long_skip, next_long_skip;
   logic [7:0] acc, next_acc;
   logic [4:0] status, next_status;
   logic [3:0] bank_pointer_reg, next_bank_pointer_reg;
   logic ext_set, next_ext_set;
   logic [11:0] idx_base, next_idx_base;
   dm_req_t next_dm;
   logic next_cycle_end, next_nop;
   logic [7:0] next_rdata;
   logic [7:0] dec_res;

   assign q_phase_o = q;
   assign dec_res = dm_rdata_i - 8'h01;

   function automatic op_t decode(input logic [15:0] w);
      if (w[15:9] == CMP_LESS_OP)
         decode = OP_CMP;
      else if (w[15:10] == DEC_FILE_OP)
         decode = OP_DEC;
      else if (w == DEC_ADJ_WORD)
         decode = OP_DAA;
      else
         decode = OP_NONE;
   endfunction

   function automatic logic is_long(input logic [15:0] w);
      is_long = (w[15:12] == MOVE_LONG_OP) || (w[15:10] == BRANCH_LONG_OP);
   endfunction

   function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f,
                                            input logic [3:0] bp, input logic ext,
                                            input logic [11:0] base);
      if (a)
         eff_addr = {bp, f};
      else if (ext && f <= OFFSET_LIMIT)
         eff_addr = base + {4'h0, f};
      else if (f <= OFFSET_LIMIT)
         eff_addr = {ACCESS_LOW_PAGE, f};
      else
         eff_addr = {ACCESS_HIGH_PAGE, f};
   endfunction

   // Carry out in bit 8; high nibble takes the low correction's carry
   function automatic logic [8:0] daa_fix(input logic [7:0] v, input logic c, input logic dc);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'b0, v[3:0]};
      if (v[3:0] > NIBBLE_MAX || dc)
         lo = lo + {1'b0, BCD_FIX};
      hi = {1'b0, v[7:4]} + {4'h0, lo[4]};
      if (hi > {1'b0, NIBBLE_MAX} || c)
         hi = hi + {1'b0, BCD_FIX};
      daa_fix = {hi[4] | c, hi[3:0], lo[3:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic [8:0] adj;
      adj = daa_fix(acc, status[FLG_C], status[FLG_DC]);
      next_q = q + 2'h1;
      next_state = state;
      next_op = op;
      next_dest_file = dest_file;
      next_skip = skip;
      next_long_skip = long_skip;
      next_acc = acc;
      next_status = status;
      next_bank_pointer_reg = bank_pointer_reg;
      next_ext_set = ext_set;
      next_idx_base = idx_base;
      next_dm = '{rd: 1'b0, wr: 1'b0, addr: dm_o.addr, wdata: dm_o.wdata};
      next_cycle_end = (q == Q3);
      next_rdata = 8'h00;
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            OFS_ACC: next_acc = reg_wdata_i;
            OFS_STATUS: next_status = reg_wdata_i[4:0];
            OFS_BANK: next_bank_pointer_reg = reg_wdata_i[3:0];
            OFS_CTRL: next_ext_set = reg_wdata_i[0];
            OFS_IDX_LO: next_idx_base = {idx_base[11:8], reg_wdata_i};
            OFS_IDX_HI: next_idx_base = {reg_wdata_i[3:0], idx_base[7:0]};
            default: ;
         endcase
      end
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            OFS_ACC: next_rdata = acc;
            OFS_STATUS: next_rdata = {3'h0, status};
            OFS_BANK: next_rdata = {4'h0, bank_pointer_reg};
            OFS_CTRL: next_rdata = {7'h00, ext_set};
            OFS_IDX_LO: next_rdata = idx_base[7:0];
            OFS_IDX_HI: next_rdata = {4'h0, idx_base[11:8]};
            default: next_rdata = 8'h00;
         endcase
      end
      unique case (q)
         Q1:
         begin
            next_skip = 1'b0;
            next_op = OP_NONE;
            if (state == ST_EXEC)
            begin
               next_op = decode(iword_i);
               next_dest_file = iword_i[9];
               if (next_op == OP_CMP || next_op == OP_DEC)
               begin
                  next_dm.rd = 1'b1;
                  next_dm.addr = eff_addr(iword_i[8], iword_i[7:0], bank_pointer_reg,
                                          ext_set, idx_base);
               end
            end
            else if (state == ST_SKIP_ONE)
               next_long_skip = is_long(iword_i);
         end
         Q2: ;
         Q3:
         begin
            unique case (op)
               OP_CMP: next_skip = dm_rdata_i < acc;
               OP_DAA:
               begin
                  next_acc = adj[7:0];
                  next_status[FLG_C] = adj[8];
               end
               OP_DEC:
               begin
                  // Decrement wins over a register-port write in the same cycle
                  if (dest_file)
                  begin
                     next_dm.wr = 1'b1;
                     next_dm.wdata = dec_res;
                  end
                  else
                     next_acc = dec_res;
                  next_status[FLG_C] = dm_rdata_i != 8'h00;
                  next_status[FLG_DC] = dm_rdata_i[3:0] != 4'h0;
                  next_status[FLG_Z] = dec_res == 8'h00;
                  next_status[FLG_OV] = dm_rdata_i == 8'h80;
                  next_status[FLG_N] = dec_res[7];
               end
               OP_NONE: ;
            endcase
         end
         Q4:
         begin
            unique case (state)
               ST_EXEC: next_state = skip ? ST_SKIP_ONE : ST_EXEC;
               ST_SKIP_ONE: next_state = long_skip ? ST_SKIP_TWO : ST_EXEC;
               ST_SKIP_TWO: next_state = ST_EXEC;
               default: next_state = ST_EXEC;
            endcase
         end
      endcase
      next_nop = (next_state != ST_EXEC);
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         q <= Q1;
         state <= ST_EXEC;
         op <= OP_NONE;
         dest_file <= 1'b0;
         skip <= 1'b0;
         long_skip <= 1'b0;
         acc <= ACC_RST;
         status <= STATUS_RST;
         bank_pointer_reg <= BANK_RST;
         ext_set <= EXT_RST;
         idx_base <= IDX_RST;
         dm_o <= '0;
         cycle_end_o <= 1'b0;
         nop_cycle_o <= 1'b0;
         reg_rdata_o <= 8'h00;
      end
      else
      begin
         q <= next_q;
         state <= next_state;
         op <= next_op;
         dest_file <= next_dest_file;
         skip <= next_skip;
         long_skip <= next_long_skip;
         acc <= next_acc;
         status <= next_status;
         bank_pointer_reg <= next_bank_pointer_reg;
         ext_set <= next_ext_set;
         idx_base <= next_idx_base;
         dm_o <= next_dm;
         cycle_end_o <= next_cycle_end;
         nop_cycle_o <= next_nop;
         reg_rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence idle_cycle;
      nop_cycle_o[*4];
   endsequence

   logic cmp_at_q3, q1_exec;
   assign cmp_at_q3 = q == Q3 && op == OP_CMP;
   assign q1_exec = q == Q1 && state == ST_EXEC;

   a_cmp_no_skip: assert property (cmp_at_q3 && !(dm_rdata_i < acc)
      |-> ##2 (!nop_cycle_o)[*4])
      else $error("compare without skip lost a cycle");
   a_cmp_skip_one: assert property (cmp_at_q3 && dm_rdata_i < acc |-> ##2 idle_cycle)
      else $error("compare skip did not idle a cycle");
   a_skip_long_word: assert property (q == Q1 && state == ST_SKIP_ONE && is_long(iword_i)
      |-> ##4 idle_cycle ##1 !nop_cycle_o)
      else $error("two-word skip did not idle two cycles");
   a_cmp_flags_kept: assert property (cmp_at_q3 |=> $stable(status) && !dm_o.wr)
      else $error("compare changed state");
   a_cmp_decode: assert property (q1_exec && iword_i[15:9] == CMP_LESS_OP
      |=> op == OP_CMP && dm_o.rd)
      else $error("compare not decoded");
   a_daa_low_fix: assert property (q == Q3 && op == OP_DAA && acc[3:0] > NIBBLE_MAX
      |=> acc[3:0] == $past(acc[3:0]) + BCD_FIX)
      else $error("low nibble not corrected");
   a_daa_high_keep: assert property (q == Q3 && op == OP_DAA && acc[7:4] < NIBBLE_MAX
      && acc[3:0] <= NIBBLE_MAX && status[1:0] == 2'h0 |=> $stable(acc))
      else $error("valid decimal byte changed");
   a_daa_carry: assert property (q == Q3 && op == OP_DAA && acc[7:4] > NIBBLE_MAX
      |=> status[FLG_C] && $stable(status[4:1]))
      else $error("decimal carry wrong");
   a_dec_zero: assert property (q == Q3 && op == OP_DEC
      |=> status[FLG_Z] == ($past(dm_rdata_i) == 8'h01))
      else $error("decrement zero flag wrong");
   a_dec_decode: assert property (q1_exec && iword_i[15:10] == DEC_FILE_OP
      |=> op == OP_DEC && dest_file == $past(iword_i[9]))
      else $error("decrement not decoded");
   a_dec_to_acc: assert property (q == Q3 && op == OP_DEC && !dest_file
      |=> acc == $past(dec_res) && !dm_o.wr)
      else $error("decrement to accumulator wrong");
   a_bank_addr: assert property (q1_exec && iword_i[8] && decode(iword_i) != OP_NONE
      && decode(iword_i) != OP_DAA
      |=> dm_o.addr == {bank_pointer_reg, $past(iword_i[7:0])})
      else $error("bank address wrong");
   a_index_addr: assert property (q1_exec && !iword_i[8] && ext_set
      && iword_i[7:0] <= OFFSET_LIMIT && decode(iword_i) == OP_DEC
      |=> dm_o.addr == $past(idx_base) + {4'h0, $past(iword_i[7:0])})
      else $error("indexed address wrong");
endmodule

/* tb/prog_mem_model.sv */
module prog_mem_model
   import exec_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // Core side
   input wire logic [1:0] q_phase_i,
   input wire dm_req_t dm_i,
   output logic [15:0] iword_o,
   output logic [7:0] dm_rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] prog [0:255];
   logic [7:0] ram [0:4095];
   logic [7:0] pc;

   initial
   begin
      foreach (prog[i])
         prog[i] = 16'h0000;
      foreach (ram[i])
         ram[i] = 8'h00;
      dm_rdata_o = 8'h00;
   end

   assign iword_o = prog[pc];

   // One word per cycle, also in discarded cycles
   always_ff @(posedge ref_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         pc <= 8'h00;
      else if (q_phase_i == Q1)
         pc <= pc + 8'h01;
   end

   // Data valid only in the cycle after the strobe, scrambled otherwise
   always @(posedge ref_clk_i)
   begin
      if (dm_i.rd)
         dm_rdata_o <= ram[dm_i.addr];
      else
         dm_rdata_o <= ~dm_rdata_o;
      if (dm_i.wr)
         ram[dm_i.addr] <= dm_i.wdata;
   end
endmodule

/* tb/testbench.sv */
`define CHK(what, exp, got) \
   begin \
      checks_done = checks_done + 1; \
      if ((got) !== (exp)) \
      begin \
         err_total = err_total + 1; \
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
      end \
   end

module testbench
   import exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [15:0] iword_i;
   logic [1:0] q_phase_o;
   logic cycle_end_o;
   logic nop_cycle_o;
   dm_req_t dm_o;
   logic [7:0] dm_rdata_i;
   logic [2:0] reg_addr_i = 3'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;

   always #2.5 ref_clk_i = ~ref_clk_i;

   exec_unit uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .iword_i(iword_i),
      .q_phase_o(q_phase_o), .cycle_end_o(cycle_end_o), .nop_cycle_o(nop_cycle_o),
      .dm_o(dm_o), .dm_rdata_i(dm_rdata_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o));

   prog_mem_model mem (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .q_phase_i(q_phase_o), .dm_i(dm_o), .iword_o(iword_i), .dm_rdata_o(dm_rdata_i));

   ////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Whole run needs about 700 cycles
   always @(posedge ref_clk_i)
   begin
      cycles = cycles + 1;
      if (cycles == 4000)
      begin
         err_total = err_total + 1;
         wrap_up();
      end
   end

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp, input string what);
      logic [7:0] v;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
      `CHK(what, exp, v)
   endtask

   // Plants the word and its follower, counts edges spent in no-operation cycles
   task automatic exec(input logic [15:0] w, input logic [15:0] w2, output int nops);
      logic [7:0] b;
      int bad;
      nops = 0;
      bad = 0;
      do
      begin
         @(posedge ref_clk_i);
         #1;
      end
      while (q_phase_o !== Q2);
      b = mem.pc;
      mem.prog[b] = w;
      mem.prog[b + 8'h01] = w2;
      for (int k = 1; k <= 24; k++)
      begin
         @(posedge ref_clk_i);
         #1;
         if (nop_cycle_o === 1'b1)
            nops++;
         // Sync left Q2 at k=0, so Q4 and the cycle end fall on k%4==2
         if (q_phase_o !== 2'((k + 1) % 4) || cycle_end_o !== (k % 4 == 2))
            bad++;
      end
      `CHK("phase and cycle end", 0, bad)
      mem.prog[b] = 16'h0000;
      mem.prog[b + 8'h01] = 16'h0000;
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      wr_reg(3'h6, 8'hFF);
      for (int i = 0; i < 8; i++)
         chk_reg(3'(i), 8'h00, "reset value");
   endtask

   // Discarded follower would decrement 020 if it ran
   task automatic t_compare();
      logic [15:0] w2s [6] = '{16'h0620, 16'hC123, 16'hEC00, 16'hC123, 16'h0000, 16'h0000};
      logic [7:0] accs [6] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h01, 8'hFF};
      logic [7:0] fs [6] = '{8'h3F, 8'h3F, 8'h3F, 8'h40, 8'hFF, 8'h00};
      int exp_n [6] = '{4, 8, 8, 0, 0, 4};
      int n;
      wr_reg(OFS_BANK, 8'h02);
      for (int i = 0; i < 6; i++)
      begin
         mem.ram[12'h230] = fs[i];
         mem.ram[12'h020] = 8'h55;
         wr_reg(OFS_ACC, accs[i]);
         wr_reg(OFS_STATUS, 8'h15);
         exec(16'h6130, w2s[i], n);
         `CHK("skip edges", exp_n[i], n)
         `CHK("discarded word", 8'h55, mem.ram[12'h020])
         chk_reg(OFS_STATUS, 8'h15, "compare status");
         chk_reg(OFS_ACC, accs[i], "compare acc");
      end
   endtask

   task automatic t_daa();
      // Last two: valid byte kept, and high nibble plus low carry without correction
      logic [7:0] in_a [7] = '{8'hA5, 8'hCE, 8'h19, 8'h42, 8'h9A, 8'h38, 8'h2C};
      logic [7:0] in_s [7] = '{8'h00, 8'h00, 8'h12, 8'h01, 8'h00, 8'h00, 8'h00};
      logic [7:0] ex_a [7] = '{8'h05, 8'h34, 8'h1F, 8'hA2, 8'h00, 8'h38, 8'h32};
      logic [7:0] ex_s [7] = '{8'h01, 8'h01, 8'h12, 8'h01, 8'h01, 8'h00, 8'h00};
      int n;
      for (int i = 0; i < 7; i++)
      begin
         wr_reg(OFS_ACC, in_a[i]);
         wr_reg(OFS_STATUS, in_s[i]);
         exec(DEC_ADJ_WORD, 16'h0000, n);
         chk_reg(OFS_ACC, ex_a[i], "adjusted acc");
         chk_reg(OFS_STATUS, ex_s[i], "adjust status");
      end
   endtask

   // Bank pointer 3, index base 1F0
   task automatic t_dec();
      logic [15:0] w [6] = '{16'h0620, 16'h0480, 16'h0745, 16'h065F, 16'h0660, 16'h065F};
      logic [11:0] ad [6] = '{12'h020, 12'hF80, 12'h345, 12'h24F, 12'hF60, 12'h05F};
      logic [7:0] op [6] = '{8'h01, 8'h00, 8'h80, 8'h10, 8'h3C, 8'hA1};
      logic [7:0] rs [6] = '{8'h00, 8'hFF, 8'h7F, 8'h0F, 8'h3B, 8'hA0};
      logic [7:0] st [6] = '{8'h07, 8'h10, 8'h09, 8'h01, 8'h03, 8'h13};
      logic [7:0] ex [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
      int n;
      wr_reg(OFS_BANK, 8'h03);
      wr_reg(OFS_IDX_LO, 8'hF0);
      wr_reg(OFS_IDX_HI, 8'h01);
      for (int i = 0; i < 6; i++)
      begin
         mem.ram[ad[i]] = op[i];
         wr_reg(OFS_CTRL, ex[i]);
         wr_reg(OFS_ACC, 8'h77);
         wr_reg(OFS_STATUS, 8'h00);
         exec(w[i], 16'h0000, n);
         `CHK("dec memory", w[i][9] ? rs[i] : op[i], mem.ram[ad[i]])
         chk_reg(OFS_ACC, w[i][9] ? 8'h77 : rs[i], "dec acc");
         chk_reg(OFS_STATUS, st[i], "dec status");
      end
   endtask

   initial
   begin
      repeat (3) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_compare();
      t_daa();
      t_dec();
      wrap_up();
   end
endmodule
